// ===== adcsr_readout.sv
// Overview of operation
// [RULE_01] CS modes: start rise begins conversion, output floats
// [RULE_02] conversion completes regardless of convert_start level
// [RULE_03] CS no-busy: start held low, MSB at end
// [RULE_04] start low presents MSB, falls shift bits
// [RULE_05] CS no-busy: float after 18th fall or rise
// [RULE_06] CS busy: drive low when conversion completes
// [RULE_07] CS busy: MSB first, float after 19th fall
// [RULE_08] host raises start before minimum conversion time
// [RULE_09] shared line: float after 18 falls or rise
// [RULE_10] daisy no-busy: MSB out, rest held internally
// [RULE_11] daisy: falls shift, upstream bit enters far end
// [RULE_12] host gives 18 falls per chained converter
// [RULE_13] daisy busy: busy indicator driven at end
// [RULE_14] host waits 50 ns after interrupt
// [RULE_15] host gives 18 times N plus one falls
// [RULE_16] mode field bits 7:6 selects output mode
// [RULE_17] sclk high at start fall: config write
// [RULE_18] short readout: leftover bits go out first
// [RULE_19] conversion time is a configurable cycle count
`timescale 1ns/10ps
`default_nettype none

module adcsr_readout #(
  parameter int RES_BITS     = adcsr_pkg::RES_BITS,
  parameter int CONV_TIME_NS = adcsr_pkg::CONV_TIME_NS
) (
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  input  wire logic                clk_en,
  input  wire logic                convert_start,
  input  wire logic                sclk,
  input  wire logic                serial_data_in,
  input  wire logic [RES_BITS-1:0] conv_result,
  output var  logic                serial_data_out,
  output var  logic                serial_data_out_oe,
  output var  logic                sample_start,
  output var  logic                conv_active,
  output var  logic [7:0]          cfg_value
);

  // ----------------------------------------------------------------
  // derived sizes
  // ----------------------------------------------------------------
  localparam int SH_W   = RES_BITS + 1;
  // least conversion time, rounded up to whole cycles
  localparam int CONV_CYCLES_RAW =
    (CONV_TIME_NS * 1000 + adcsr_pkg::CLK_PERIOD_PS - 1) / adcsr_pkg::CLK_PERIOD_PS;
  localparam int CONV_CYCLES = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
  localparam int CNT_W  = $clog2(CONV_CYCLES + 1);
  localparam int LEFT_W = $clog2(SH_W + 1);
  localparam int CFGC_W = $clog2(adcsr_pkg::CFG_BITS + 1);

  localparam logic [CNT_W-1:0]  CONV_LAST   = CNT_W'(CONV_CYCLES - 1);
  localparam logic [LEFT_W-1:0] LEFT_NOBUSY = LEFT_W'(RES_BITS);
  localparam logic [LEFT_W-1:0] LEFT_BUSY   = LEFT_W'(RES_BITS + 1);
  localparam logic [CFGC_W-1:0] CFG_LAST    = CFGC_W'(adcsr_pkg::CFG_BITS - 1);

  generate
    if (RES_BITS < 2) begin : g_chk_res
      $error("adcsr_readout: RES_BITS must be at least 2");
    end
    if (CONV_TIME_NS < 1) begin : g_chk_conv
      $error("adcsr_readout: CONV_TIME_NS must be positive");
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic       cs_s;
  logic       sclk_s;
  logic       din_s;

  adcsr_sync #(
    .W (3)
  ) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .clk_en  (clk_en),
    .d_in    ({convert_start, sclk, serial_data_in}),
    .d_out   (pins_s)
  );

  assign cs_s   = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s  = pins_s[0];

  // ----------------------------------------------------------------
  // edge detection on synchronised pins
  // ----------------------------------------------------------------
  logic cs_prev_q;
  logic sclk_prev_q;
  logic cs_rise;
  logic cs_fall;
  logic sclk_fall;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cs_prev_q   <= 1'b0;
      sclk_prev_q <= 1'b0;
    end else if (clk_en) begin
      cs_prev_q   <= cs_s;
      sclk_prev_q <= sclk_s;
    end
  end

  assign cs_rise   = cs_s & ~cs_prev_q;
  assign cs_fall   = ~cs_s & cs_prev_q;
  assign sclk_fall = ~sclk_s & sclk_prev_q;

  // ----------------------------------------------------------------
  // sequencer: acquisition, conversion, configuration write
  // ----------------------------------------------------------------
  adcsr_pkg::adcsr_state_t state_q;
  logic [CNT_W-1:0]        conv_cnt_q;
  logic [CFGC_W-1:0]       cfg_cnt_q;
  logic [7:0]              cfg_sh_q;
  logic [7:0]              cfg_q;
  logic [1:0]              mode_q;
  logic                    start_q;
  logic                    done;
  logic                    cs_mode;
  logic                    busy_mode;

  assign done      = (state_q == adcsr_pkg::ST_CONV) && (conv_cnt_q == '0);
  assign cs_mode   = (mode_q == adcsr_pkg::MODE_CS_NOBUSY) ||
                     (mode_q == adcsr_pkg::MODE_CS_BUSY);
  assign busy_mode = (mode_q == adcsr_pkg::MODE_CS_BUSY) ||
                     (mode_q == adcsr_pkg::MODE_DC_BUSY);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q    <= adcsr_pkg::ST_ACQ;
      conv_cnt_q <= '0;
      mode_q     <= adcsr_pkg::MODE_CS_NOBUSY;
      start_q    <= 1'b0;
    end else if (clk_en) begin
      start_q <= 1'b0;
      case (state_q)
        adcsr_pkg::ST_ACQ: begin
          if (cs_rise) begin
            // new settings take effect at the next conversion only
            state_q    <= adcsr_pkg::ST_CONV; // RULE_01
            conv_cnt_q <= CONV_LAST; // RULE_19
            mode_q     <= cfg_q[adcsr_pkg::MODE_MSB:adcsr_pkg::MODE_LSB]; // RULE_16
            start_q    <= 1'b1;
          end else if (cs_fall && sclk_s) begin
            state_q <= adcsr_pkg::ST_CFG; // RULE_17
          end
        end
        adcsr_pkg::ST_CONV: begin
          // convert_start is not looked at here, so the host may reuse it
          if (conv_cnt_q == '0) begin
            state_q <= adcsr_pkg::ST_ACQ; // RULE_02
          end else begin
            conv_cnt_q <= conv_cnt_q - 1'b1; // RULE_19
          end
        end
        adcsr_pkg::ST_CFG: begin
          if (cs_rise || (sclk_fall && cfg_cnt_q == CFG_LAST)) begin
            state_q <= adcsr_pkg::ST_ACQ;
          end
        end
        default: begin
          state_q <= adcsr_pkg::ST_ACQ;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg_cnt_q <= '0;
      cfg_sh_q  <= adcsr_pkg::CFG_RESET;
      cfg_q     <= adcsr_pkg::CFG_RESET;
    end else if (clk_en) begin
      if (state_q != adcsr_pkg::ST_CFG) begin
        cfg_cnt_q <= '0;
        cfg_sh_q  <= cfg_q;
      end else if (sclk_fall) begin
        cfg_sh_q  <= {cfg_sh_q[6:0], din_s}; // RULE_17
        cfg_cnt_q <= cfg_cnt_q + 1'b1;
        if (cfg_cnt_q == CFG_LAST) begin
          cfg_q <= {cfg_sh_q[6:0], din_s}; // RULE_17
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // result shifter and output drive
  // ----------------------------------------------------------------
  logic [SH_W-1:0]   sh_q;
  logic [LEFT_W-1:0] left_q;
  logic              oe_q;
  logic              shift_ok;

  assign shift_ok = (state_q == adcsr_pkg::ST_ACQ) && ~cs_s && sclk_fall;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sh_q   <= '0;
      left_q <= '0;
      oe_q   <= 1'b0;
    end else if (clk_en) begin
      if (done) begin
        // unread bits of an older result are kept and the new result is dropped
        if (left_q == '0) begin // RULE_18
          if (busy_mode) begin
            sh_q   <= {adcsr_pkg::BUSY_LEVEL, conv_result}; // RULE_06 RULE_13
            left_q <= LEFT_BUSY;
          end else begin
            sh_q   <= {conv_result, 1'b0}; // RULE_10
            left_q <= LEFT_NOBUSY;
          end
        end
        if (mode_q == adcsr_pkg::MODE_CS_NOBUSY) begin
          oe_q <= ~cs_s; // RULE_03
        end else begin
          oe_q <= 1'b1; // RULE_06 RULE_10 RULE_13
        end
      end else if (state_q == adcsr_pkg::ST_ACQ && !cfg_q[adcsr_pkg::MODE_MSB] && cs_rise) begin
        // the mode about to be latched governs the conversion this edge starts
        oe_q <= 1'b0; // RULE_01 RULE_05 RULE_07 RULE_09
      end else if (state_q == adcsr_pkg::ST_ACQ && cs_mode && cs_fall && !sclk_s) begin
        oe_q <= (left_q != '0); // RULE_04
      end else if (shift_ok && !cs_mode) begin
        // the chain keeps moving for as many edges as the host gives
        // without a busy bit the chain is one stage shorter: the spare stage stays empty
        if (busy_mode) begin
          sh_q <= {sh_q[SH_W-2:0], din_s}; // RULE_11 RULE_15
        end else begin
          sh_q <= {sh_q[SH_W-2:1], din_s, 1'b0}; // RULE_11 RULE_12
        end
        if (left_q != '0) begin
          left_q <= left_q - 1'b1;
        end
      end else if (shift_ok && oe_q && left_q != '0) begin
        sh_q   <= {sh_q[SH_W-2:0], 1'b0}; // RULE_04
        left_q <= left_q - 1'b1;
        if (left_q == LEFT_W'(1)) begin
          oe_q <= 1'b0; // RULE_05 RULE_07 RULE_09
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic sdo_q;
  logic sdo_oe_q;
  logic active_q;
  logic cfg_daisy;

  assign cfg_daisy = cfg_q[adcsr_pkg::MODE_MSB];

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sdo_q    <= 1'b0;
      sdo_oe_q <= 1'b0;
      active_q <= 1'b0;
    end else if (clk_en) begin
      // in a chain the configuration byte passes on to the next part
      if (state_q == adcsr_pkg::ST_CFG && cfg_daisy) begin
        sdo_q <= cfg_sh_q[7];
      end else begin
        sdo_q <= sh_q[SH_W-1];
      end
      sdo_oe_q <= oe_q;
      active_q <= (state_q == adcsr_pkg::ST_CONV);
    end
  end

  assign serial_data_out    = sdo_q;
  assign serial_data_out_oe = sdo_oe_q;
  assign sample_start       = start_q;
  assign conv_active        = active_q;
  assign cfg_value          = cfg_q;

endmodule

`default_nettype wire

// ===== adcsr_pkg.sv
package adcsr_pkg;

  // ----------------------------------------------------------------
  // result and configuration layout
  // ----------------------------------------------------------------
  localparam int         RES_BITS   = 18;
  localparam int         CFG_BITS   = 8;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam int         MODE_MSB   = 7;
  localparam int         MODE_LSB   = 6;

  // ----------------------------------------------------------------
  // output mode encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_CS_NOBUSY = 2'h0;
  localparam logic [1:0] MODE_CS_BUSY   = 2'h1;
  localparam logic [1:0] MODE_DC_NOBUSY = 2'h2;
  localparam logic [1:0] MODE_DC_BUSY   = 2'h3;

  // level driven as the busy (conversion done) indicator
  localparam logic       BUSY_LEVEL     = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_PS  = 5000;
  localparam int         CONV_TIME_NS   = 2000;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACQ,
    ST_CONV,
    ST_CFG
  } adcsr_state_t;

endpackage

// ===== adcsr_sync.sv
`timescale 1ns/10ps
`default_nettype none

module adcsr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] d_out
);

  logic [W-1:0] meta_q;

  generate
    if (W < 1) begin : g_chk
      $error("adcsr_sync: W must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // two-stage synchroniser, one per pin
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          meta_q[i] <= 1'b0;
          d_out[i]  <= 1'b0;
        end else if (clk_en) begin
          meta_q[i] <= d_in[i];
          d_out[i]  <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== adcsr_readout_props.sv
`timescale 1ns/10ps
`default_nettype none

module adcsr_readout_props #(
  parameter int RES_BITS     = adcsr_pkg::RES_BITS,
  parameter int CONV_TIME_NS = adcsr_pkg::CONV_TIME_NS
) (
  input wire logic                clk_sys,
  input wire logic                nrst,
  input wire logic                clk_en,
  input wire logic                convert_start,
  input wire logic                sclk,
  input wire logic                serial_data_in,
  input wire logic [RES_BITS-1:0] conv_result,
  input wire logic                serial_data_out,
  input wire logic                serial_data_out_oe,
  input wire logic                sample_start,
  input wire logic                conv_active,
  input wire logic [7:0]          cfg_value
);
  localparam int CONV_CYC = CONV_TIME_NS * 1000 / adcsr_pkg::CLK_PERIOD_PS;
  localparam int END_LO   = CONV_CYC - 1;
  localparam int END_HI   = CONV_CYC + 2;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_start_pulse: assert property (sample_start |=> !sample_start)
    else $error("start pulse too long");
  a_start_conv: assert property (sample_start |-> ##[0:2] conv_active)
    else $error("no conversion after start");
  a_conv_hold: assert property ($rose(conv_active) |-> conv_active [*8])
    else $error("conversion cut short");
  a_conv_len: assert property ($rose(conv_active) |-> ##[END_LO:END_HI] !conv_active)
    else $error("conversion length wrong");
  a_cs_float: assert property (sample_start && !cfg_value[7] |-> ##3 !serial_data_out_oe [*5])
    else $error("output driven while converting");
  a_rise_float: assert property ($rose(convert_start) && !cfg_value[7] |-> ##[2:8] !serial_data_out_oe)
    else $error("output not released on select rise");
  a_busy_flag: assert property ($fell(conv_active) && cfg_value[6]
    |-> ##[0:3] (serial_data_out_oe && serial_data_out == adcsr_pkg::BUSY_LEVEL))
    else $error("busy level missing at end");
  a_daisy_drive: assert property (cfg_value[7] && serial_data_out_oe |=> serial_data_out_oe)
    else $error("chain output released");
endmodule

bind adcsr_readout adcsr_readout_props #(
  .RES_BITS     (RES_BITS),
  .CONV_TIME_NS (CONV_TIME_NS)
) props_u (
  .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .convert_start(convert_start),
  .sclk(sclk), .serial_data_in(serial_data_in), .conv_result(conv_result),
  .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
  .sample_start(sample_start), .conv_active(conv_active), .cfg_value(cfg_value)
);

`default_nettype wire

// ===== adcsr_host.sv
`timescale 1ns/10ps
`default_nettype none

module adcsr_host (
  input  wire logic clk_sys,
  input  wire logic line,
  output var  logic convert_start,
  output var  logic sclk,
  output var  logic serial_data_in
);
  // sclk idles low so a select fall never enters config by accident
  initial begin
    convert_start = 1'b0;
    sclk = 1'b0;
    serial_data_in = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic select(input logic v, input int n);
    convert_start <= v;
    cyc(n);
  endtask

  // long phases: pins pass a synchronizer, output moves ~4 cycles after a fall
  task automatic shift(input logic d, output logic q);
    serial_data_in <= d;
    sclk <= 1'b1;
    cyc(8);
    sclk <= 1'b0;
    cyc(8);
    q = line;
  endtask
endmodule

`default_nettype wire

// ===== tb_adc_serial_readout_modes.sv
`timescale 1ns/10ps
`default_nettype none

module tb_adc_serial_readout_modes;
  localparam int          CONV_NS = 50;
  localparam logic [17:0] R1      = 18'h1D3A5;
  localparam logic [17:0] R2      = 18'h0A5C3;
  localparam logic [17:0] R3      = 18'h3FFFF;
  localparam logic [17:0] R4      = 18'h2C96B;
  localparam logic [17:0] R5      = 18'h15A3C;
  localparam logic [17:0] R6      = 18'h2B6D9;
  logic        clk_sys, nrst, clk_en, convert_start, sclk, serial_data_in, line, q;
  logic        serial_data_out, serial_data_out_oe, sample_start, conv_active;
  logic [17:0] conv_result;
  logic [7:0]  cfg_value;
  int          fails, total_checks;

  // shared line has a pull-up, so a released pin reads high
  assign line = serial_data_out_oe ? serial_data_out : 1'b1;

  adcsr_readout #(.CONV_TIME_NS(CONV_NS)) dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .clk_en(clk_en), .convert_start(convert_start),
    .sclk(sclk), .serial_data_in(serial_data_in), .conv_result(conv_result),
    .serial_data_out(serial_data_out), .serial_data_out_oe(serial_data_out_oe),
    .sample_start(sample_start), .conv_active(conv_active), .cfg_value(cfg_value)
  );

  adcsr_host host_u (
    .clk_sys(clk_sys), .line(line), .convert_start(convert_start),
    .sclk(sclk), .serial_data_in(serial_data_in)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic seen, input logic exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %b expected %b", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic do_reset;
    nrst <= 1'b0;
    host_u.cyc(6);
    nrst <= 1'b1;
    host_u.cyc(2);
    check(cfg_value === adcsr_pkg::CFG_RESET, 1'b1);
    check(serial_data_out_oe, 1'b0);
  endtask

  task automatic convert(input logic [17:0] r, input logic lo);
    int n;
    conv_result <= r;
    host_u.select(1'b1, 6);
    if (!cfg_value[7]) check(serial_data_out_oe, 1'b0);
    if (lo) host_u.select(1'b0, 1);
    for (n = 0; n < 60 && conv_active !== 1'b0; n++) host_u.cyc(1);
    if (n == 60) begin
      fails++;
      results();
    end
    host_u.cyc(8);
  endtask

  // bit e[k-j] is expected after fall j; upstream input repeats p
  task automatic read(input int k, input logic [20:0] e, input logic [3:0] p);
    int j;
    for (j = 1; j <= k; j++) begin
      host_u.shift(p[(j - 1) % 4], q);
      check(q, e[k - j]);
    end
  endtask

  // one conversion always precedes entry; it carries the same result
  task automatic load_cfg(input logic [7:0] v, input logic [17:0] r);
    int j;
    convert(r, 1'b0);
    host_u.sclk <= 1'b1;
    host_u.cyc(6);
    host_u.select(1'b0, 6);
    for (j = 7; j >= 0; j--) host_u.shift(v[j], q);
    check(cfg_value === v, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic s_cs_plain;
    convert(R1, 1'b1);
    check(line, R1[17]);
    // a fall given while the clock enable is low must be lost
    clk_en <= 1'b0;
    host_u.shift(1'b0, q);
    clk_en <= 1'b1;
    check(q, R1[17]);
    read(17, 21'(R1), 4'h0);
    host_u.shift(1'b0, q);
    check(serial_data_out_oe, 1'b0);
  endtask

  task automatic s_cs_short;
    convert(R2, 1'b1);
    read(5, 21'(R2 >> 12), 4'h0);
    convert(R3, 1'b1);
    check(line, R2[12]);
    read(12, 21'(R2), 4'h0);
    host_u.shift(1'b0, q);
    check(serial_data_out_oe, 1'b0);
  endtask

  task automatic s_cs_busy;
    load_cfg(8'h40, R4);
    check(line, adcsr_pkg::BUSY_LEVEL);
    read(18, 21'(R4), 4'h0);
    host_u.shift(1'b0, q);
    convert(R4, 1'b0);
    check(serial_data_out_oe, 1'b1);
    check(line, adcsr_pkg::BUSY_LEVEL);
    host_u.select(1'b0, 6);
    read(18, 21'(R4), 4'h0);
    host_u.shift(1'b0, q);
    check(serial_data_out_oe, 1'b0);
  endtask

  task automatic s_daisy;
    load_cfg(8'h80, R5);
    convert(R5, 1'b0);
    check(line, R5[17]);
    host_u.select(1'b0, 6);
    read(21, {R5[16:0], 4'hB}, 4'hD);
    load_cfg(8'hC0, R6);
    check(line, R6[17]);
    read(17, 21'(R6), 4'h0);
    host_u.shift(1'b0, q);
    convert(R6, 1'b0);
    check(line, adcsr_pkg::BUSY_LEVEL);
    host_u.cyc(10);
    host_u.select(1'b0, 6);
    read(21, {R6, 3'h5}, 4'hD);
  endtask

  initial begin
    nrst = 1'b0;
    clk_en = 1'b1;
    conv_result = 18'h00000;
    fails = 0;
    total_checks = 0;
    do_reset();
    s_cs_plain();
    s_cs_short();
    do_reset();
    s_daisy();
    s_cs_busy();
    results();
  end
endmodule

`default_nettype wire
